//--- hdl/iag_consts.svh
`ifndef IAG_CONSTS_SVH
`define IAG_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define IAG_BANK_OFFSET 16'hfff3
`define IAG_BANK_RESET 8'h00
`define IAG_RDATA_RESET 8'h00

// ----------------------------------------
// Address formation
// ----------------------------------------
`define IAG_PC_RESET 16'h0000
`define IAG_DISP_SIGN_BIT 7
`define IAG_PC_W 16
`define IAG_BANK_W 8
`define IAG_LEN_W 3

`endif

//--- hdl/iag_pkg.sv
`include "iag_consts.svh"

package iag_pkg;
	typedef logic [`IAG_PC_W-1:0] iag_pc_t;
	typedef logic [`IAG_BANK_W-1:0] iag_bank_t;
	typedef logic [`IAG_LEN_W-1:0] iag_len_t;
	typedef logic [7:0] iag_disp_t;
	typedef enum logic [1:0] {
		IAG_BR_NONE,
		IAG_BR_REL,
		IAG_BR_ABS
	} iag_br_kind_t;
endpackage : iag_pkg

//--- hdl/iag_rel_adder.sv
`timescale 1ns/1ps
`include "iag_consts.svh"

module iag_rel_adder (
	iag_rel_if.calc rel
);
	iag_pkg::iag_pc_t next_instr;
	iag_pkg::iag_pc_t disp_ext;

	always_comb begin
		// Start of the instruction after the branch
		next_instr = rel.pc + {{(`IAG_PC_W-`IAG_LEN_W){1'b0}}, rel.len};
		// Upper bits copy the sign bit
		disp_ext = {{(`IAG_PC_W-8){rel.disp[`IAG_DISP_SIGN_BIT]}}, rel.disp};
		// Carry out of the top bit is dropped
		rel.target = next_instr + disp_ext;
	end
endmodule : iag_rel_adder

//--- hdl/iag_rel_if.sv
`timescale 1ns/1ps

interface iag_rel_if;
	iag_pkg::iag_pc_t pc;
	iag_pkg::iag_len_t len;
	iag_pkg::iag_disp_t disp;
	iag_pkg::iag_pc_t target;

	modport calc (input pc, input len, input disp, output target);
	modport user (output pc, output len, output disp, input target);
endinterface : iag_rel_if

//--- hdl/iag_top.sv
`timescale 1ns/1ps
`include "iag_consts.svh"

module iag_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction completion from decoder
	input wire logic instr_done,
	input wire iag_pkg::iag_len_t instr_len,
	input wire iag_pkg::iag_br_kind_t br_kind,
	input wire iag_pkg::iag_disp_t branch_displacement,
	input wire iag_pkg::iag_pc_t br_target,
	// Special function register port
	input wire logic [15:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Fetch address to fetch unit
	output iag_pkg::iag_pc_t fetch_pc,
	output iag_pkg::iag_bank_t fetch_bank,
	output logic [`IAG_BANK_W+`IAG_PC_W-1:0] fetch_addr
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	iag_pkg::iag_pc_t pc_r;
	iag_pkg::iag_pc_t pc_nxt;
	iag_pkg::iag_bank_t bank_r;
	iag_pkg::iag_bank_t bank_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [`IAG_BANK_W+`IAG_PC_W-1:0] addr_r;
	logic [`IAG_BANK_W+`IAG_PC_W-1:0] addr_nxt;
	logic bank_hit;
	logic signed [16:0] rel_ref;

	iag_rel_if rel ();

	iag_rel_adder u_rel_adder (
		.rel(rel.calc)
	);

	// ----------------------------------------
	// Next address
	// ----------------------------------------
	always_comb begin
		rel.pc = pc_r;
		rel.len = instr_len;
		rel.disp = branch_displacement;
		pc_nxt = pc_r;
		if (instr_done) begin
			case (br_kind)
				iag_pkg::IAG_BR_REL: pc_nxt = rel.target;
				iag_pkg::IAG_BR_ABS: pc_nxt = br_target;
				iag_pkg::IAG_BR_NONE: pc_nxt = pc_r + {13'h0000, instr_len};
				default: pc_nxt = pc_r + {13'h0000, instr_len};
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_r <= `IAG_PC_RESET;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// ----------------------------------------
	// Bank select register
	// ----------------------------------------
	always_comb begin
		bank_hit = (sfr_addr == `IAG_BANK_OFFSET);
		bank_nxt = bank_r;
		if (sfr_wr && bank_hit) begin
			bank_nxt = sfr_wdata;
		end
		rdata_nxt = rdata_r;
		if (sfr_rd) begin
			rdata_nxt = bank_hit ? bank_r : 8'h00;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_r <= `IAG_BANK_RESET;
			rdata_r <= `IAG_RDATA_RESET;
		end else begin
			bank_r <= bank_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Fetch address
	// ----------------------------------------
	always_comb begin
		addr_nxt = {bank_nxt, pc_nxt};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_r <= {`IAG_BANK_RESET, `IAG_PC_RESET};
		end else begin
			addr_r <= addr_nxt;
		end
	end

	assign fetch_pc = pc_r;
	assign fetch_bank = bank_r;
	assign fetch_addr = addr_r;
	assign sfr_rdata = rdata_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	addr_combines_a: assert property (fetch_addr == {fetch_bank, fetch_pc})
		else $error("fetch address not bank joined with counter");
	seq_step_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_NONE
		|=> fetch_pc == $past(pc_r) + {13'h0000, $past(instr_len)})
		else $error("sequential step wrong");
	seq_wrap_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_NONE && pc_r == 16'hfffe
		&& instr_len == 3'h4 |=> fetch_pc == 16'h0002)
		else $error("sequential step did not wrap");
	code_default_a: assert property (
		instr_done && br_kind == iag_pkg::iag_br_kind_t'(2'h3)
		|=> fetch_pc == 16'($past(pc_r) + $past(instr_len)))
		else $error("unknown branch code not sequential");
	idle_hold_a: assert property (!instr_done |=> $stable(fetch_pc))
		else $error("counter moved without instruction");
	abs_load_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_ABS |=> fetch_pc == $past(br_target))
		else $error("branch destination not loaded");
	addr_lower_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_ABS |=> fetch_addr[15:0] == $past(br_target))
		else $error("fetch address missed branch destination");
	rel_target_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_REL
		|=> fetch_pc == 16'($past(pc_r) + $past(instr_len)
			+ {{8{$past(branch_displacement[7])}}, $past(branch_displacement)}))
		else $error("relative target wrong");
	rel_back_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_REL && branch_displacement == 8'h80
		|=> fetch_pc == 16'($past(pc_r) + $past(instr_len) - 16'h0080))
		else $error("negative reach wrong");
	rel_reach_fwd_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_REL && !branch_displacement[7]
		|=> 16'(fetch_pc - $past(pc_r) - $past(instr_len)) <= 16'h007f)
		else $error("forward reach exceeded");
	rel_reach_back_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_REL && branch_displacement[7]
		|=> 16'($past(pc_r) + $past(instr_len) - fetch_pc) inside {[16'h0001:16'h0080]})
		else $error("backward reach exceeded");
	rel_wrap_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_REL && pc_r == 16'hfffe
		&& instr_len == 3'h2 && branch_displacement == 8'h7f |=> fetch_pc == 16'h007f)
		else $error("relative target did not wrap");

	// Signed reference for the relative target
	always_comb begin
		rel_ref = $signed({1'b0, pc_r}) + $signed({14'h0000, instr_len})
			+ $signed(branch_displacement);
	end
	rel_signed_a: assert property (
		instr_done && br_kind == iag_pkg::IAG_BR_REL |=> fetch_pc == $past(rel_ref[15:0]))
		else $error("relative target differs from signed sum");

	// ----------------------------------------
	// Register checks
	// ----------------------------------------
	bank_write_a: assert property (
		sfr_wr && sfr_addr == `IAG_BANK_OFFSET |=> fetch_bank == $past(sfr_wdata))
		else $error("bank write not taken");
	addr_upper_a: assert property (
		sfr_wr && sfr_addr == `IAG_BANK_OFFSET |=> fetch_addr[23:16] == $past(sfr_wdata))
		else $error("fetch address missed bank write");
	bank_other_a: assert property (
		sfr_wr && sfr_addr != `IAG_BANK_OFFSET |=> $stable(fetch_bank))
		else $error("write to other address changed bank");
	bank_keep_a: assert property (
		!(sfr_wr && sfr_addr == `IAG_BANK_OFFSET) |=> $stable(fetch_bank))
		else $error("bank changed without write");
	bank_read_a: assert property (
		sfr_rd && sfr_addr == `IAG_BANK_OFFSET |=> sfr_rdata == $past(fetch_bank))
		else $error("bank readback wrong");
	read_other_a: assert property (
		sfr_rd && sfr_addr != `IAG_BANK_OFFSET |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");

	// ----------------------------------------
	// Reset check
	// ----------------------------------------
	rst_values_a: assert property (@(posedge clk) disable iff (1'b0)
		rst |-> fetch_pc == `IAG_PC_RESET && fetch_bank == `IAG_BANK_RESET
		&& fetch_addr == {`IAG_BANK_RESET, `IAG_PC_RESET} && sfr_rdata == `IAG_RDATA_RESET)
		else $error("reset values wrong");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	rel_fwd_c: cover property (instr_done && br_kind == iag_pkg::IAG_BR_REL
		&& !branch_displacement[7]);
	rel_back_c: cover property (instr_done && br_kind == iag_pkg::IAG_BR_REL
		&& branch_displacement[7]);
	abs_c: cover property (instr_done && br_kind == iag_pkg::IAG_BR_ABS);
	bank_c: cover property (sfr_wr && sfr_addr == `IAG_BANK_OFFSET ##1 instr_done);
	read_c: cover property (sfr_rd && sfr_addr == `IAG_BANK_OFFSET ##1 sfr_rdata != 8'h00);
endmodule : iag_top

//--- verification/iag_dec_model.sv
`timescale 1ns/1ps

module iag_dec_model (
	// Bench command
	input wire logic go,
	input wire iag_pkg::iag_len_t len,
	input wire iag_pkg::iag_br_kind_t kind,
	input wire iag_pkg::iag_disp_t disp,
	input wire iag_pkg::iag_pc_t tgt,
	// Decoder side
	output logic instr_done,
	output iag_pkg::iag_len_t instr_len,
	output iag_pkg::iag_br_kind_t br_kind,
	output iag_pkg::iag_disp_t branch_displacement,
	output iag_pkg::iag_pc_t br_target
);
	// Fields inverted between pulses
	always_comb begin
		instr_done = go;
		instr_len = go ? len : ~len;
		br_kind = go ? kind : iag_pkg::iag_br_kind_t'(~kind);
		branch_displacement = go ? disp : ~disp;
		br_target = go ? tgt : ~tgt;
	end
endmodule : iag_dec_model

//--- verification/tb.sv
`timescale 1ns/1ps

module tb;
	logic clk, rst, go, wr, rd, dn;
	logic [2:0] len, il;
	logic [15:0] tgt, pc_m, bt, addr, fpc;
	logic [7:0] disp, bd, wd, rdata, bank_m, fb;
	logic [23:0] fa;
	iag_pkg::iag_br_kind_t kind, bk;
	int seed, error_cnt, cmp_count;
	iag_dec_model iag_dec_model_inst (.go(go), .len(len), .kind(kind), .disp(disp), .tgt(tgt),
		.instr_done(dn), .instr_len(il), .br_kind(bk), .branch_displacement(bd), .br_target(bt));
	iag_top iag_top_inst (.clk(clk), .rst(rst), .instr_done(dn), .instr_len(il), .br_kind(bk),
		.branch_displacement(bd), .br_target(bt), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_wdata(wd), .sfr_rdata(rdata), .fetch_pc(fpc), .fetch_bank(fb), .fetch_addr(fa));
	function automatic logic [15:0] nxt(input logic [2:0] l, input logic [7:0] d);
		if (kind == iag_pkg::IAG_BR_ABS) return tgt;
		if (kind == iag_pkg::IAG_BR_REL) return pc_m + l + {{8{d[7]}}, d};
		return pc_m + l;
	endfunction : nxt
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic ins(input iag_pkg::iag_br_kind_t k, input logic [2:0] l, input logic [7:0] d);
		{go, wr, rd, len, disp} = {3'b100, l, d};
		kind = k;
		@(posedge clk) #1;
		pc_m = nxt(l, d);
		chk(fa, {bank_m, pc_m});
		chk({fb, fpc}, {bank_m, pc_m});
	endtask : ins
	task automatic sfr(input logic w, input logic [15:0] a, input logic [7:0] d);
		{go, wr, rd, addr, wd} = {1'b0, w, !w, a, d};
		@(posedge clk) #1;
		if (w && a == 16'hfff3) bank_m = d;
		if (w) chk(fa, {bank_m, pc_m});
		else chk(rdata, (a == 16'hfff3) ? bank_m : 8'h00);
	endtask : sfr
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50us;
		error_cnt++;
		wrap_up;
	end
	initial begin
		seed = 32'ha0e5;
		{go, wr, rd, addr, wd, len, disp, tgt, pc_m, bank_m} = '0;
		kind = iag_pkg::IAG_BR_NONE;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		chk(fa, 24'h000000);
		chk(rdata, 8'h00);
		ins(iag_pkg::IAG_BR_REL, 3'h2, 8'h80);
		ins(iag_pkg::IAG_BR_REL, 3'h4, 8'h7f);
		ins(iag_pkg::IAG_BR_REL, 3'h2, 8'hfe);
		tgt = 16'hfffe;
		ins(iag_pkg::IAG_BR_ABS, 3'h3, 8'h05);
		ins(iag_pkg::IAG_BR_NONE, 3'h4, 8'h7f);
		ins(iag_pkg::IAG_BR_ABS, 3'h3, 8'h05);
		ins(iag_pkg::IAG_BR_REL, 3'h2, 8'h7f);
		ins(iag_pkg::iag_br_kind_t'(2'h3), 3'h1, 8'h10);
		sfr(1'b1, 16'hfff3, 8'ha5);
		sfr(1'b0, 16'hfff3, 8'h00);
		rst = 1'b1;
		@(posedge clk) #1;
		chk(fa, 24'h000000);
		chk(rdata, 8'h00);
		{pc_m, bank_m} = '0;
		@(posedge clk) #1 rst = 1'b0;
		sfr(1'b1, 16'hfff2, 8'h3c);
		sfr(1'b0, 16'hfff4, 8'h00);
		repeat (80) begin
			tgt = 16'($random(seed));
			if ($unsigned($random(seed)) % 6 == 0) sfr(1'b1, 16'hfff3, 8'($random(seed)));
			else ins(iag_pkg::iag_br_kind_t'($unsigned($random(seed)) % 3),
				3'($unsigned($random(seed)) % 4 + 1), 8'($random(seed)));
		end
		{go, wr} = 2'b00;
		repeat (3) @(posedge clk);
		#1 chk(fa, {bank_m, pc_m});
		wrap_up;
	end
endmodule : tb
